// *** include/fsu_pkg.sv ***
// Constants, register map and carrier types of the float stack command unit.
package fsu_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS   = 8'h08;

    // ------------------------------------------------------------------
    // Command opcodes (low seven bits of the command byte)
    // ------------------------------------------------------------------
    localparam int         SRQ_BIT              = 7;
    localparam logic [6:0] CLEAR_STATUS_CMD     = 7'h00;
    localparam logic [6:0] SINGLE_ADD_CMD       = 7'h01;
    localparam logic [6:0] SINGLE_SUBTRACT_CMD  = 7'h02;
    localparam logic [6:0] SINGLE_MULTIPLY_CMD  = 7'h03;
    localparam logic [6:0] SINGLE_DIVIDE_CMD    = 7'h04;
    localparam logic [6:0] SINGLE_PUSH_CMD      = 7'h06;
    localparam logic [6:0] SINGLE_POP_CMD       = 7'h07;
    localparam logic [6:0] DOUBLE_ADD_CMD       = 7'h29;
    localparam logic [6:0] DOUBLE_SUBTRACT_CMD  = 7'h2A;
    localparam logic [6:0] DOUBLE_MULTIPLY_CMD  = 7'h2B;
    localparam logic [6:0] DOUBLE_DIVIDE_CMD    = 7'h2C;
    localparam logic [6:0] DOUBLE_PUSH_CMD      = 7'h2E;
    localparam int         DBL_SEL_BIT          = 5;

    // ------------------------------------------------------------------
    // Number formats, stack and timing
    // ------------------------------------------------------------------
    localparam logic [12:0] SGL_BIAS     = 13'h007F;
    localparam logic [12:0] DBL_BIAS     = 13'h03FF;
    localparam logic [12:0] SGL_EMAX     = 13'h00FF;
    localparam logic [12:0] DBL_EMAX     = 13'h07FF;
    localparam int          SGL_LSB_POS  = 29;
    localparam int          STK_DEPTH    = 8;
    localparam int          STK_AW       = 3;
    localparam logic [5:0]  CLEAR_CYCLES = 6'h04;
    localparam logic [5:0]  DIV_STEPS    = 6'h38;
    localparam logic [7:0]  STATUS_RST   = 8'h00;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic busy;
        logic sign;
        logic zero;
        logic rsv4;
        logic dvz;
        logic unf;
        logic ovf;
        logic rsv0;
    } fsu_status_t;

    typedef struct packed {
        logic        sgn;
        logic [12:0] exp;
        logic [52:0] man;
    } fsu_unp_t;

    typedef enum logic [2:0] {
        KIND_CTL = 3'h0,
        KIND_ADD = 3'h1,
        KIND_SUB = 3'h2,
        KIND_MUL = 3'h3,
        KIND_DIV = 3'h4
    } fsu_kind_t;

endpackage

// *** rtl/fsu_command_unit.sv ***
// Float stack command unit: AHB-Lite registers, operand stack and rounding FP datapath.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module fsu_command_unit (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // AHB-Lite slave
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic                hreadyout,
    output logic                hresp,
    output logic [31:0]         hrdata,
    // Status view
    output fsu_pkg::fsu_status_t status
);
    import fsu_pkg::*;

    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_FIN = 3'b100} fsu_state_t;

    fsu_state_t        state_reg;
    fsu_kind_t         kind_reg;
    logic [6:0]        op_reg;
    logic [7:0]        cmd_reg;
    logic              dbl_reg;
    logic              dz_reg;
    logic [5:0]        cnt_reg;
    fsu_unp_t          a_reg;
    fsu_unp_t          b_reg;
    logic [63:0]       bw_reg;
    logic [56:0]       raw_reg;
    logic [12:0]       rexp_reg;
    logic              rsgn_reg;
    logic [55:0]       q_reg;
    logic [53:0]       rem_reg;
    logic              sign_reg, zero_reg, dvz_reg, unf_reg, ovf_reg;
    logic [31:0]       stk_reg [STK_DEPTH];
    logic [STK_AW-1:0] tp_reg;
    logic              pend_reg, pw_reg, rdok_reg;
    logic [7:0]        pa_reg;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic fsu_unp_t unp(input logic dbl, input logic [63:0] x);
        fsu_unp_t u;
        u.sgn = dbl ? x[63] : x[31];
        if (dbl) begin
            u.exp = {2'b00, x[62:52]} - DBL_BIAS;
            u.man = (x[62:52] == 11'h000) ? 53'h0 : {1'b1, x[51:0]};
        end else begin
            u.exp = {5'b00000, x[30:23]} - SGL_BIAS;
            u.man = (x[30:23] == 8'h00) ? 53'h0 : {1'b1, x[22:0], 29'h0};
        end
        return u;
    endfunction

    function automatic fsu_kind_t op_kind(input logic [6:0] op);
        case (op)
            DOUBLE_ADD_CMD, SINGLE_ADD_CMD:           return KIND_ADD;
            DOUBLE_SUBTRACT_CMD, SINGLE_SUBTRACT_CMD: return KIND_SUB;
            DOUBLE_MULTIPLY_CMD, SINGLE_MULTIPLY_CMD: return KIND_MUL;
            DOUBLE_DIVIDE_CMD, SINGLE_DIVIDE_CMD:     return KIND_DIV;
            default:                                  return KIND_CTL;
        endcase
    endfunction

    // Right shift that folds every lost bit into bit 0 as sticky.
    function automatic logic [55:0] shr_st(input logic [55:0] v, input logic [12:0] d);
        logic [55:0] r;
        logic        lost;
        r    = (d > 13'h0037) ? 56'h0 : v >> d;
        lost = (d > 13'h0037) ? |v : ((r << d) != v);
        return {r[55:1], r[0] | lost};
    endfunction

    // ------------------------------------------------------------------
    // Stack words and bus decode
    // ------------------------------------------------------------------
    logic [31:0] w0, w1, w2, w3;
    logic        busy, blocked, cmd_go, data_wr, data_rd, ctl_done;
    logic        go_dbl;
    fsu_kind_t   go_kind;
    fsu_unp_t    go_a, go_b;
    logic [63:0] go_bw;

    assign w0       = stk_reg[tp_reg];
    assign w1       = stk_reg[tp_reg - 3'h1];
    assign w2       = stk_reg[tp_reg - 3'h2];
    assign w3       = stk_reg[tp_reg - 3'h3];
    assign busy     = (state_reg != ST_IDLE);
    // Command and data accesses wait out a running command; status accesses never do.
    assign blocked  = pend_reg & busy & ((pa_reg == CMD_OFS) | (pa_reg == DATA_OFS));
    assign cmd_go   = pend_reg & pw_reg & !blocked & (pa_reg == CMD_OFS);
    assign data_wr  = pend_reg & pw_reg & !blocked & (pa_reg == DATA_OFS);
    assign data_rd  = pend_reg & !pw_reg & !blocked & !rdok_reg & (pa_reg == DATA_OFS);
    assign ctl_done = (state_reg == ST_RUN) & (kind_reg == KIND_CTL) & (cnt_reg == 6'h00);
    assign go_dbl   = hwdata[DBL_SEL_BIT];
    assign go_kind  = op_kind(hwdata[6:0]);
    assign go_bw    = go_dbl ? {w2, w3} : {32'h0, w1};
    assign go_a     = unp(go_dbl, go_dbl ? {w0, w1} : {32'h0, w0});
    assign go_b     = unp(go_dbl, go_bw);

    assign hreadyout = !pend_reg | (!blocked & (pw_reg | rdok_reg));
    assign hresp     = 1'b0;

    always_comb begin
        status      = STATUS_RST;
        status.busy = busy;
        status.sign = sign_reg;
        status.zero = zero_reg;
        status.dvz  = dvz_reg;
        status.unf  = unf_reg;
        status.ovf  = ovf_reg;
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave: data phase tracking and read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_reg <= 1'b0;
            pw_reg   <= 1'b0;
            pa_reg   <= 8'h00;
            rdok_reg <= 1'b0;
            hrdata   <= 32'h0;
        end else begin
            if (hready) begin
                pend_reg <= hsel & htrans[1];
                pw_reg   <= hwrite;
                pa_reg   <= haddr[7:0];
                rdok_reg <= 1'b0;
            end else if (pend_reg & !pw_reg & !blocked & !rdok_reg) begin
                rdok_reg <= 1'b1;
                case (pa_reg)
                    CMD_OFS:    hrdata <= {24'h0, cmd_reg};
                    STATUS_OFS: hrdata <= {24'h0, status};
                    DATA_OFS:   hrdata <= w0;
                    default:    hrdata <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Arithmetic front end
    // ------------------------------------------------------------------
    logic        a_big, sa, sb, sbig, ssml;
    logic [12:0] ediff;
    logic [55:0] mbig, msml;
    logic [56:0] raw_c;
    logic [12:0] rexp_c;
    logic        rsgn_c;
    logic [105:0] prod;

    always_comb begin
        a_big  = $signed(a_reg.exp) >= $signed(b_reg.exp);
        sa     = a_reg.sgn ^ (kind_reg == KIND_SUB);
        sb     = b_reg.sgn;
        ediff  = a_big ? a_reg.exp - b_reg.exp : b_reg.exp - a_reg.exp;
        mbig   = a_big ? {a_reg.man, 3'b000} : {b_reg.man, 3'b000};
        msml   = shr_st(a_big ? {b_reg.man, 3'b000} : {a_reg.man, 3'b000}, ediff);
        sbig   = a_big ? sa : sb;
        ssml   = a_big ? sb : sa;
        prod   = a_reg.man * b_reg.man;
        rsgn_c = a_reg.sgn ^ b_reg.sgn;
        raw_c  = {prod[105:50], prod[49] | (|prod[48:0])};
        rexp_c = a_reg.exp + b_reg.exp;
        if (kind_reg == KIND_DIV) begin
            rexp_c = b_reg.exp - a_reg.exp;
        end else if (kind_reg != KIND_MUL) begin
            rexp_c = a_big ? a_reg.exp : b_reg.exp;
            if (sbig == ssml) begin
                raw_c  = {1'b0, mbig} + {1'b0, msml};
                rsgn_c = sbig;
            end else if (mbig >= msml) begin
                raw_c  = {1'b0, mbig - msml};
                rsgn_c = sbig;
            end else begin
                raw_c  = {1'b0, msml - mbig};
                rsgn_c = ssml;
            end
        end
    end

    // ------------------------------------------------------------------
    // Normalise, round to nearest even, pack
    // ------------------------------------------------------------------
    logic [56:0] raw_f, t;
    logic [5:0]  lead;
    logic [12:0] en, be;
    logic [52:0] mant;
    logic [53:0] mr;
    logic        g, r, st, lsb, rz, r_unf, r_ovf;
    logic [63:0] res;

    always_comb begin
        raw_f = (kind_reg == KIND_DIV) ? {1'b0, q_reg[55:1], q_reg[0] | (|rem_reg)} : raw_reg;
        lead  = 6'h00;
        for (int i = 0; i < 57; i++) begin
            if (raw_f[i]) begin
                lead = 6'(i);
            end
        end
        rz = (raw_f == 57'h0);
        t  = raw_f << (6'h38 - lead);
        en = rexp_reg + {7'h00, lead} - 13'h0037;
        if (dbl_reg) begin
            mant = t[56:4];
            g    = t[3];
            r    = t[2];
            st   = |t[1:0];
            lsb  = t[4];
        end else begin
            mant = {t[56:33], 29'h0};
            g    = t[32];
            r    = t[31];
            st   = |t[30:0];
            lsb  = t[33];
        end
        mr = {1'b0, mant} + (54'(g & (r | st | lsb)) << (dbl_reg ? 0 : SGL_LSB_POS));
        if (mr[53]) begin
            mant = mr[53:1];
            en   = en + 13'h0001;
        end else begin
            mant = mr[52:0];
        end
        be    = en + (dbl_reg ? DBL_BIAS : SGL_BIAS);
        r_ovf = !rz & ($signed(be) >= $signed(dbl_reg ? DBL_EMAX : SGL_EMAX));
        r_unf = !rz & ($signed(be) <= $signed(13'h0000));
        // Overflow saturates the exponent field; underflow flushes to zero.
        if (rz | r_unf) begin
            res = 64'h0;
        end else if (dbl_reg) begin
            res = {rsgn_reg, r_ovf ? 11'h7FF : be[10:0], r_ovf ? 52'h0 : mant[51:0]};
        end else begin
            res = {32'h0, rsgn_reg, r_ovf ? 8'hFF : be[7:0], r_ovf ? 23'h0 : mant[51:29]};
        end
        if (dz_reg) begin
            res   = bw_reg;
            r_ovf = 1'b0;
            r_unf = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer and divider
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            kind_reg  <= KIND_CTL;
            op_reg    <= 7'h00;
            cmd_reg   <= 8'h00;
            dbl_reg   <= 1'b0;
            dz_reg    <= 1'b0;
            cnt_reg   <= 6'h00;
            a_reg     <= '0;
            b_reg     <= '0;
            bw_reg    <= 64'h0;
            raw_reg   <= 57'h0;
            rexp_reg  <= 13'h0000;
            rsgn_reg  <= 1'b0;
            q_reg     <= 56'h0;
            rem_reg   <= 54'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (cmd_go) begin
                        cmd_reg   <= hwdata[7:0];
                        op_reg    <= hwdata[6:0];
                        kind_reg  <= go_kind;
                        dbl_reg   <= go_dbl;
                        a_reg     <= go_a;
                        b_reg     <= go_b;
                        bw_reg    <= go_bw;
                        q_reg     <= 56'h0;
                        rem_reg   <= {1'b0, go_b.man};
                        dz_reg    <= (go_kind == KIND_DIV) & (go_a.man == 53'h0);
                        cnt_reg   <= (go_kind == KIND_CTL) ? CLEAR_CYCLES - 6'h01 :
                                     DIV_STEPS - 6'h01;
                        state_reg <= ((go_kind == KIND_DIV) & (go_a.man == 53'h0)) ? ST_FIN : ST_RUN;
                    end
                end
                ST_RUN: begin
                    raw_reg  <= raw_c;
                    rexp_reg <= rexp_c;
                    rsgn_reg <= rsgn_c;
                    if (kind_reg == KIND_DIV) begin
                        if (rem_reg >= {1'b0, a_reg.man}) begin
                            q_reg   <= {q_reg[54:0], 1'b1};
                            rem_reg <= (rem_reg - {1'b0, a_reg.man}) << 1;
                        end else begin
                            q_reg   <= {q_reg[54:0], 1'b0};
                            rem_reg <= rem_reg << 1;
                        end
                    end
                    if (kind_reg != KIND_CTL && kind_reg != KIND_DIV) begin
                        state_reg <= ST_FIN;
                    end else if (cnt_reg == 6'h00) begin
                        state_reg <= (kind_reg == KIND_DIV) ? ST_FIN : ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
                ST_FIN: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    logic [31:0] push_word;
    assign push_word = (w0[30:23] == 8'h00) ? 32'h0 : w0;

    always_ff @(posedge clk) begin
        if (rst | cmd_go) begin
            sign_reg <= 1'b0;
            zero_reg <= 1'b0;
            dvz_reg  <= 1'b0;
            unf_reg  <= 1'b0;
            ovf_reg  <= 1'b0;
        end else if (ctl_done) begin
            case (op_reg)
                SINGLE_POP_CMD: begin
                    sign_reg <= w1[31];
                    zero_reg <= (w1[30:23] == 8'h00);
                end
                DOUBLE_PUSH_CMD: begin
                    sign_reg <= w0[31];
                    zero_reg <= ({w0, w1} == 64'h0);
                end
                SINGLE_PUSH_CMD: begin
                    sign_reg <= push_word[31];
                    zero_reg <= (push_word == 32'h0);
                end
                default: begin
                end
            endcase
        end else if (state_reg == ST_FIN) begin
            sign_reg <= dbl_reg ? res[63] : res[31];
            zero_reg <= (res == 64'h0);
            dvz_reg  <= dz_reg;
            unf_reg  <= r_unf;
            ovf_reg  <= r_ovf;
        end
    end

    // ------------------------------------------------------------------
    // Operand stack: circular, so a pop rotates the old top to the bottom
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            tp_reg <= '0;
        end else if (data_wr) begin
            stk_reg[tp_reg + 3'h1] <= hwdata;
            tp_reg                 <= tp_reg + 3'h1;
        end else if (data_rd) begin
            tp_reg <= tp_reg - 3'h1;
        end else if (ctl_done) begin
            case (op_reg)
                SINGLE_POP_CMD: begin
                    tp_reg <= tp_reg - 3'h1;
                end
                DOUBLE_PUSH_CMD: begin
                    stk_reg[tp_reg + 3'h1] <= w1;
                    stk_reg[tp_reg + 3'h2] <= w0;
                    tp_reg                 <= tp_reg + 3'h2;
                end
                SINGLE_PUSH_CMD: begin
                    stk_reg[tp_reg + 3'h1] <= push_word;
                    tp_reg                 <= tp_reg + 3'h1;
                end
                default: begin
                end
            endcase
        end else if (state_reg == ST_FIN) begin
            if (dbl_reg) begin
                stk_reg[tp_reg - 3'h2] <= res[63:32];
                stk_reg[tp_reg - 3'h3] <= res[31:0];
                tp_reg                 <= tp_reg - 3'h2;
            end else begin
                stk_reg[tp_reg - 3'h1] <= res[31:0];
                tp_reg                 <= tp_reg - 3'h1;
            end
        end
    end

endmodule // fsu_command_unit

// *** sim/fsu_command_unit_properties.sv ***
// Checker of the float stack command unit seen at its ports.
`timescale 1ns/1ps
module fsu_command_unit_properties (
    // Clock and reset
    input logic                clk,
    input logic                rst,
    // Bus
    input logic                hsel,
    input logic [31:0]         haddr,
    input logic [1:0]          htrans,
    input logic                hwrite,
    input logic [2:0]          hsize,
    input logic [31:0]         hwdata,
    input logic                hready,
    input logic                hreadyout,
    input logic                hresp,
    input logic [31:0]         hrdata,
    // Status
    input fsu_pkg::fsu_status_t status
);
    import fsu_pkg::*;
    logic cmd_ph;
    wire  go = cmd_ph && hreadyout;
    // A command only starts when its data phase completes, so stalled writes are not counted.
    always_ff @(posedge clk) begin
        if (rst) cmd_ph <= 1'b0;
        else if (hready) cmd_ph <= hsel && htrans[1] && hwrite && haddr[7:0] == CMD_OFS;
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    reset_clear_a: assert property ($fell(rst) |-> status == STATUS_RST) else $error("status not cleared");
    busy_start_a: assert property (go |=> status == 8'h80) else $error("busy not raised");
    busy_flags_a: assert property (status.busy |-> status[6:0] == 7'h00) else $error("flags during busy");
    clear_time_a: assert property (go && hwdata[6:0] == CLEAR_STATUS_CMD |=> status.busy [*4] ##1 status == 8'h00)
        else $error("clear timing");
    arith_time_a: assert property (go && hwdata[6:0] inside {7'h01, 7'h02, 7'h03, 7'h29, 7'h2A, 7'h2B}
        |=> status.busy [*2] ##1 !status.busy) else $error("arith timing");
    rsv_zero_a: assert property (!status.rsv0 && !status.rsv4) else $error("reserved bit set");
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
    move_flags_a: assert property (go && hwdata[6:0] inside {7'h06, 7'h07, 7'h2E}
        |=> ##4 !status.busy && status[3:1] == 3'h0) else $error("move flags");
    div_time_a: assert property (go && hwdata[6:0] inside {7'h04, 7'h2C}
        |=> status.busy ##[1:57] !status.busy) else $error("divide timing");
    cover property (go && hwdata[6:0] == CLEAR_STATUS_CMD);
    cover property (status.dvz);
    cover property (status.ovf && !status.busy);
    cover property (status.zero && !status.busy);
endmodule // fsu_command_unit_properties
bind fsu_command_unit fsu_command_unit_properties u_props (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .status(status));

// *** sim/fsu_host.sv ***
// Host model issuing single-word bus transfers to the unit.
`timescale 1ns/1ps
module fsu_host (
    // Clock and answer
    input  logic        clk,
    input  logic        hready,
    input  logic [31:0] hrdata,
    // Request
    output logic        hsel,
    output logic [31:0] haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata
);
    int gap = 0;
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    // Holds a phase until hready is seen high at a falling edge; read data is taken at that edge.
    task automatic ph(output logic [31:0] q);
        logic r;
        do begin
            @(negedge clk);
            r = hready;
            q = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        repeat (gap) @(posedge clk);
        {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, 24'h0, a, 2'b10, w, 3'h2};
        ph(q);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        ph(q);
    endtask
endmodule // fsu_host

// *** sim/fsu_command_unit_test.sv ***
// Self-checking bench of the float stack command unit.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("BAD %0t %h %h", $time, g, e); end end
module fsu_command_unit_test;
    import fsu_pkg::*;
    typedef struct {logic [7:0] c; logic [63:0] a; logic [63:0] b; logic [63:0] r; logic [7:0] s;} fsu_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q, q2;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [63:0] res;
    fsu_status_t status;
    fsu_row_t    rw [15];
    int          err_total = 0;
    int          n_tests = 0;
    always #10 clk = ~clk;
    fsu_host u_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    fsu_command_unit DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .status(status));
    task automatic put(input logic [63:0] v, input logic d);
        if (d) u_host.xfer(DATA_OFS, 1'b1, v[31:0], q);
        u_host.xfer(DATA_OFS, 1'b1, d ? v[63:32] : v[31:0], q);
    endtask
    // Polls until busy drops; the last status word stays in q.
    task automatic run(input logic [7:0] c);
        u_host.xfer(CMD_OFS, 1'b1, {24'h0, c}, q);
        for (int k = 0; k < 100; k++) begin
            u_host.xfer(STATUS_OFS, 1'b0, 32'h0, q);
            if (q[7] === 1'b0) break;
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        print_verdict();
    end
    initial begin
        rw[0] = '{8'h81, 64'h40000000, 64'h3F800000, 64'h40400000, 8'h00};
        rw[1] = '{8'h02, 64'h40000000, 64'h3F800000, 64'hBF800000, 8'h40};
        rw[2] = '{8'h83, 64'h40000000, 64'h40400000, 64'h40C00000, 8'h00};
        rw[3] = '{8'h04, 64'h40000000, 64'h40400000, 64'h3FC00000, 8'h00};
        rw[4] = '{8'h84, 64'h00400000, 64'h3F800000, 64'h3F800000, 8'h08};
        rw[5] = '{8'h07, 64'h3F800000, 64'h00400000, 64'h00400000, 8'h20};
        rw[6] = '{8'h86, 64'hBF800000, 64'h0, 64'hBF800000, 8'h40};
        rw[7] = '{8'hA9, 64'h4000000000000000, 64'h3FF0000000000000, 64'h4008000000000000, 8'h00};
        rw[8] = '{8'h2A, 64'h4000000000000000, 64'h3FF0000000000000, 64'hBFF0000000000000, 8'h40};
        rw[9] = '{8'hAB, 64'h4000000000000000, 64'h4008000000000000, 64'h4018000000000000, 8'h00};
        rw[10] = '{8'h2C, 64'h4000000000000000, 64'h4008000000000000, 64'h3FF8000000000000, 8'h00};
        rw[11] = '{8'hAC, 64'h0, 64'h3FF0000000000000, 64'h3FF0000000000000, 8'h08};
        rw[12] = '{8'h2E, 64'hC000000000000000, 64'h0, 64'hC000000000000000, 8'h40};
        rw[13] = '{8'h83, 64'h7F000000, 64'h7F000000, 64'h7F800000, 8'h02};
        rw[14] = '{8'h03, 64'h00800000, 64'h00800000, 64'h0, 8'h24};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(status, STATUS_RST)
        foreach (rw[i]) begin
            put(rw[i].b, rw[i].c[DBL_SEL_BIT]);
            put(rw[i].a, rw[i].c[DBL_SEL_BIT]);
            run(rw[i].c);
            `CHK(q[7:0], rw[i].s)
            u_host.xfer(DATA_OFS, 1'b0, 32'h0, q2);
            res = {32'h0, q2};
            if (rw[i].c[DBL_SEL_BIT]) begin
                u_host.xfer(DATA_OFS, 1'b0, 32'h0, q);
                res = {q2, q};
            end
            `CHK(res, rw[i].r)
        end
        // A clear written during a long divide stalls, then must leave the quotient in place.
        put(64'h4008000000000000, 1'b1);
        put(64'h4000000000000000, 1'b1);
        u_host.xfer(CMD_OFS, 1'b1, 32'h2C, q);
        run(8'h80);
        `CHK(q[7:0], 8'h00)
        u_host.gap = 2;
        u_host.xfer(DATA_OFS, 1'b0, 32'h0, q);
        `CHK(q, 32'h3FF80000)
        u_host.xfer(CMD_OFS, 1'b1, 32'hAC, q);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(status, STATUS_RST)
        print_verdict();
    end
endmodule // fsu_command_unit_test
